// >>> rtl/timer16_pkg.sv
// Shared constants, types and decoders for the 16-bit timer access block
package timer16_pkg;
  // Byte addresses on the 8-bit I/O bus
  localparam int         ADDR_W      = 4;
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CNT_L  = 4'h1;
  localparam logic [3:0] ADDR_CNT_H  = 4'h2;
  localparam logic [3:0] ADDR_CMPA_L = 4'h3;
  localparam logic [3:0] ADDR_CMPA_H = 4'h4;
  localparam logic [3:0] ADDR_CMPB_L = 4'h5;
  localparam logic [3:0] ADDR_CMPB_H = 4'h6;
  localparam logic [3:0] ADDR_CAP_L  = 4'h7;
  localparam logic [3:0] ADDR_CAP_H  = 4'h8;

  // Control register A layout
  localparam int         MODE_A_POS   = 6;
  localparam int         MODE_B_POS   = 4;
  localparam int         WGM_LO_POS   = 0;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] TEMP_RESET   = 8'h00;
  localparam logic [15:0] CMP_RESET   = 16'h0000;
  localparam logic [15:0] BOTTOM      = 16'h0000;

  // Output mode codes
  localparam logic [1:0] OUT_OFF    = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_CLEAR  = 2'h2;
  localparam logic [1:0] OUT_SET    = 2'h3;

  typedef enum logic [2:0] {
    WAVE_NONPWM = 3'h1,
    WAVE_FAST   = 3'h2,
    WAVE_DUAL   = 3'h4
  } wave_class_type;

  typedef struct packed {
    logic at_top;
    logic at_bottom;
    logic counting_down;
  } counter_status_type;

  typedef struct packed {
    logic level;
    logic enable;
    logic override;
  } pin_drive_type;

  function automatic wave_class_type wave_class(input logic [3:0] wgm);
    case (wgm)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: wave_class = WAVE_DUAL;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf:             wave_class = WAVE_FAST;
      default:                                  wave_class = WAVE_NONPWM;
    endcase
  endfunction : wave_class

  // Phase and frequency correct modes reload compares at BOTTOM
  function automatic logic reload_at_bottom(input logic [3:0] wgm);
    reload_at_bottom = (wgm == 4'h8) || (wgm == 4'h9);
  endfunction : reload_at_bottom
endpackage : timer16_pkg

// >>> rtl/waveform_channel.sv
// One compare output channel: pin level from output mode and waveform mode
`timescale 1ns/1ps
module waveform_channel #(
  parameter bit IS_CHAN_A = 1'b1
) (
  // Clock and reset
  input  wire logic                            sys_clk_in,
  input  wire logic                            rst_in,
  // Timer events
  input  wire logic                            tick_in,
  input  wire logic                            match_in,
  input  wire timer16_pkg::counter_status_type status_in,
  input  wire logic                            cmp_eq_top_in,
  input  wire logic                            cmp_eq_bottom_in,
  // Configuration
  input  wire logic [1:0]                      mode_in,
  input  wire logic [3:0]                      wgm_in,
  // Result
  output logic                                 level_out,
  output logic                                 connected_out
);
  timer16_pkg::wave_class_type wclass;
  logic                        toggle_ok;
  logic                        level_q;
  logic                        level_d;

  assign wclass    = timer16_pkg::wave_class(wgm_in);
  // Channel B toggle in PWM is reserved, so it stays off the pin
  assign toggle_ok = (wclass == timer16_pkg::WAVE_NONPWM) ||
                     (wgm_in[3] && IS_CHAN_A); // see [R14]
  assign connected_out = (mode_in != timer16_pkg::OUT_OFF) &&
                         (mode_in != timer16_pkg::OUT_TOGGLE || toggle_ok);
  assign level_out = level_q;

  always_comb begin
    level_d = level_q;
    if (tick_in) begin // see [R1]
      if (mode_in == timer16_pkg::OUT_TOGGLE) begin
        if (match_in && toggle_ok) begin
          level_d = ~level_q; // see [R12] see [R14]
        end
      end else if (mode_in[1]) begin
        unique case (wclass)
          timer16_pkg::WAVE_NONPWM: begin
            if (match_in) level_d = mode_in[0]; // see [R12]
          end
          timer16_pkg::WAVE_FAST: begin
            if (status_in.at_bottom) level_d = ~mode_in[0]; // see [R13]
            if (match_in && !cmp_eq_top_in) begin
              level_d = mode_in[0]; // see [R13] see [R15]
            end
          end
          timer16_pkg::WAVE_DUAL: begin
            if (cmp_eq_bottom_in) begin
              level_d = mode_in[0]; // see [R17]
            end else if (cmp_eq_top_in) begin
              level_d = ~mode_in[0]; // see [R17]
            end else if (match_in) begin
              level_d = status_in.counting_down ? ~mode_in[0]
                                                : mode_in[0]; // see [R16]
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_d;
    end
  end

  toggle_step_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    tick_in && match_in && mode_in == timer16_pkg::OUT_TOGGLE && toggle_ok
    |=> level_out != $past(level_out)) // see [R12]
    else $error("toggle on match did not invert the output");

  fast_bottom_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    tick_in && wclass == timer16_pkg::WAVE_FAST && mode_in[1] &&
    status_in.at_bottom && !(match_in && !cmp_eq_top_in)
    |=> level_out == ~$past(mode_in[0])) // see [R13]
    else $error("fast PWM bottom action wrong");

  dual_slope_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    tick_in && wclass == timer16_pkg::WAVE_DUAL && mode_in[1] && match_in &&
    !cmp_eq_top_in && !cmp_eq_bottom_in
    |=> level_out == ($past(mode_in[0]) ^ $past(status_in.counting_down)))
    else $error("dual slope match action wrong"); // see [R16]

  dual_extreme_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    tick_in && wclass == timer16_pkg::WAVE_DUAL && mode_in[1] &&
    cmp_eq_bottom_in |=> level_out == $past(mode_in[0])) // see [R17]
    else $error("compare at bottom did not hold output level");

  reserved_b_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wclass != timer16_pkg::WAVE_NONPWM && mode_in == timer16_pkg::OUT_TOGGLE
    && (!wgm_in[3] || !IS_CHAN_A) |-> !connected_out) // see [R14]
    else $error("reserved toggle mode reached the pin");
endmodule : waveform_channel

// >>> rtl/timer16_byte_access_compare_out.sv
// Byte access to the 16-bit timer registers and the two compare outputs
//
// Behaviour
// [R1] Everything runs on the I/O clock; the timer tick is only an enable.
// [R2] Phase and frequency correct PWM reloads compares at BOTTOM.
// [R3] One 8-bit high-byte holding register serves all 16-bit registers.
// [R4] Low-byte access does the 16-bit transfer; high byte only the holder.
// [R5] Low-byte write loads held high byte and written low byte together.
// [R6] Low-byte read captures that register's high byte into the holder.
// [R7] Compare reads return both bytes directly, leaving the holder untouched.
// [R8] Software writes high byte first, and reads low byte first.
// [R9] Software masks interrupts around two-byte accesses that handlers share.
// [R10] Software may write the held high byte once for several registers.
// [R11] Nonzero output mode overrides the pin; driven only if direction out.
// [R12] Non-PWM codes on match: off, toggle, clear, set.
// [R13] Fast PWM: 10 clears on match, sets at BOTTOM; 11 the opposite.
// [R14] PWM code 01: off unless mode bit 3; then A toggles, B reserved.
// [R15] Fast PWM with compare at TOP ignores match but keeps BOTTOM action.
// [R16] Dual slope: 10 clears on up match, sets on down match; 11 opposite.
// [R17] Dual slope: compare at BOTTOM holds low, at TOP high; inverted swaps.
`timescale 1ns/1ps
module timer16_byte_access_compare_out (
  // Clock and reset
  input  wire logic                               sys_clk_in,
  input  wire logic                               rst_in,
  // CPU I/O bus
  input  wire logic [timer16_pkg::ADDR_W-1:0]     io_addr_in,
  input  wire logic [7:0]                         io_wdata_in,
  input  wire logic                               io_wr_in,
  input  wire logic                               io_rd_in,
  output logic      [7:0]                         io_rdata_out,
  // Counter side
  input  wire logic                               timer_tick_enable_in,
  input  wire logic [15:0]                        counter_value_in,
  input  wire logic [15:0]                        capture_value_in,
  input  wire logic [15:0]                        top_value_in,
  input  wire timer16_pkg::counter_status_type    status_in,
  input  wire logic                               match_a_in,
  input  wire logic                               match_b_in,
  input  wire logic [1:0]                         waveform_mode_hi_in,
  output logic      [1:0]                         waveform_mode_lo_out,
  output logic      [15:0]                        load_value_out,
  output logic                                    counter_load_out,
  output logic                                    capture_load_out,
  output logic      [15:0]                        compare_value_a_out,
  output logic      [15:0]                        compare_value_b_out,
  // Pins
  input  wire logic                               dir_a_in,
  input  wire logic                               dir_b_in,
  output timer16_pkg::pin_drive_type              waveform_out_a_out,
  output timer16_pkg::pin_drive_type              waveform_out_b_out
);
  logic [7:0]  ctrl_a_q;
  logic [7:0]  temp_q;
  logic [15:0] buf_a_q;
  logic [15:0] buf_b_q;
  logic [15:0] cmp_a_q;
  logic [15:0] cmp_b_q;
  logic [7:0]  rd_value;
  logic [3:0]  wgm;
  logic        reload;
  logic        level_a;
  logic        level_b;
  logic        conn_a;
  logic        conn_b;
  logic [1:0]  mode_a;
  logic [1:0]  mode_b;

  function automatic logic is_addr(input logic strobe,
                                   input logic [3:0] addr,
                                   input logic [3:0] want);
    is_addr = strobe && (addr == want);
  endfunction : is_addr

  assign wgm    = {waveform_mode_hi_in, ctrl_a_q[timer16_pkg::WGM_LO_POS+:2]};
  assign mode_a = ctrl_a_q[timer16_pkg::MODE_A_POS+:2];
  assign mode_b = ctrl_a_q[timer16_pkg::MODE_B_POS+:2];
  assign waveform_mode_lo_out = ctrl_a_q[timer16_pkg::WGM_LO_POS+:2];
  assign compare_value_a_out  = cmp_a_q;
  assign compare_value_b_out  = cmp_b_q;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_a_q <= timer16_pkg::CTRL_A_RESET;
    end else if (is_addr(io_wr_in, io_addr_in, timer16_pkg::ADDR_CTRL_A)) begin
      ctrl_a_q <= io_wdata_in;
    end
  end

  // Single holder: an interrupted two-byte access is corrupted by design
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      temp_q <= timer16_pkg::TEMP_RESET;
    end else if (io_wr_in && (io_addr_in == timer16_pkg::ADDR_CNT_H ||
                              io_addr_in == timer16_pkg::ADDR_CMPA_H ||
                              io_addr_in == timer16_pkg::ADDR_CMPB_H ||
                              io_addr_in == timer16_pkg::ADDR_CAP_H)) begin
      temp_q <= io_wdata_in; // see [R3] see [R4] see [R10]
    end else if (is_addr(io_rd_in, io_addr_in, timer16_pkg::ADDR_CNT_L)) begin
      temp_q <= counter_value_in[15:8]; // see [R6]
    end else if (is_addr(io_rd_in, io_addr_in, timer16_pkg::ADDR_CAP_L)) begin
      temp_q <= capture_value_in[15:8]; // see [R6]
    end
  end

  // Low-byte writes fire the 16-bit transfer
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      load_value_out   <= 16'h0000;
      counter_load_out <= 1'b0;
      capture_load_out <= 1'b0;
    end else begin
      load_value_out   <= {temp_q, io_wdata_in}; // see [R5]
      counter_load_out <= is_addr(io_wr_in, io_addr_in,
                                  timer16_pkg::ADDR_CNT_L); // see [R4]
      capture_load_out <= is_addr(io_wr_in, io_addr_in,
                                  timer16_pkg::ADDR_CAP_L); // see [R4]
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      buf_a_q <= timer16_pkg::CMP_RESET;
      buf_b_q <= timer16_pkg::CMP_RESET;
    end else begin
      if (is_addr(io_wr_in, io_addr_in, timer16_pkg::ADDR_CMPA_L)) begin
        buf_a_q <= {temp_q, io_wdata_in}; // see [R5]
      end
      if (is_addr(io_wr_in, io_addr_in, timer16_pkg::ADDR_CMPB_L)) begin
        buf_b_q <= {temp_q, io_wdata_in}; // see [R5]
      end
    end
  end

  // Non-PWM modes follow the buffer at once; PWM reloads on a tick only
  assign reload = timer_tick_enable_in &&
                  (timer16_pkg::reload_at_bottom(wgm) ? status_in.at_bottom
                                                      : status_in.at_top);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmp_a_q <= timer16_pkg::CMP_RESET;
      cmp_b_q <= timer16_pkg::CMP_RESET;
    end else if (timer16_pkg::wave_class(wgm) == timer16_pkg::WAVE_NONPWM ||
                 reload) begin // see [R1] see [R2]
      cmp_a_q <= buf_a_q;
      cmp_b_q <= buf_b_q;
    end
  end

  always_comb begin
    unique case (io_addr_in)
      timer16_pkg::ADDR_CTRL_A: rd_value = ctrl_a_q;
      timer16_pkg::ADDR_CNT_L:  rd_value = counter_value_in[7:0];
      timer16_pkg::ADDR_CNT_H:  rd_value = temp_q;
      timer16_pkg::ADDR_CMPA_L: rd_value = buf_a_q[7:0]; // see [R7]
      timer16_pkg::ADDR_CMPA_H: rd_value = buf_a_q[15:8]; // see [R7]
      timer16_pkg::ADDR_CMPB_L: rd_value = buf_b_q[7:0]; // see [R7]
      timer16_pkg::ADDR_CMPB_H: rd_value = buf_b_q[15:8]; // see [R7]
      timer16_pkg::ADDR_CAP_L:  rd_value = capture_value_in[7:0];
      timer16_pkg::ADDR_CAP_H:  rd_value = temp_q;
      default:                  rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      io_rdata_out <= 8'h00;
    end else if (io_rd_in) begin
      io_rdata_out <= rd_value;
    end
  end

  waveform_channel #(.IS_CHAN_A(1'b1)) chan_a (
    .sys_clk_in       (sys_clk_in),
    .rst_in           (rst_in),
    .tick_in          (timer_tick_enable_in),
    .match_in         (match_a_in),
    .status_in        (status_in),
    .cmp_eq_top_in    (cmp_a_q == top_value_in),
    .cmp_eq_bottom_in (cmp_a_q == timer16_pkg::BOTTOM),
    .mode_in          (mode_a),
    .wgm_in           (wgm),
    .level_out        (level_a),
    .connected_out    (conn_a)
  );

  waveform_channel #(.IS_CHAN_A(1'b0)) chan_b (
    .sys_clk_in       (sys_clk_in),
    .rst_in           (rst_in),
    .tick_in          (timer_tick_enable_in),
    .match_in         (match_b_in),
    .status_in        (status_in),
    .cmp_eq_top_in    (cmp_b_q == top_value_in),
    .cmp_eq_bottom_in (cmp_b_q == timer16_pkg::BOTTOM),
    .mode_in          (mode_b),
    .wgm_in           (wgm),
    .level_out        (level_b),
    .connected_out    (conn_b)
  );

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      waveform_out_a_out <= '0;
      waveform_out_b_out <= '0;
    end else begin
      waveform_out_a_out <= '{level: level_a, enable: conn_a && dir_a_in,
                              override: conn_a}; // see [R11]
      waveform_out_b_out <= '{level: level_b, enable: conn_b && dir_b_in,
                              override: conn_b}; // see [R11]
    end
  end

  sequence cnt_low_write_s;
    is_addr(io_wr_in, io_addr_in, timer16_pkg::ADDR_CNT_L);
  endsequence

  sequence load_seen_s(logic [15:0] v);
    counter_load_out && load_value_out == v;
  endsequence

  low_write_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    cnt_low_write_s |=> load_seen_s({$past(temp_q), $past(io_wdata_in)}))
    else $error("low byte write did not load both bytes"); // see [R5]

  high_write_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    is_addr(io_wr_in, io_addr_in, timer16_pkg::ADDR_CNT_H)
    |=> !counter_load_out && temp_q == $past(io_wdata_in)) // see [R4]
    else $error("high byte write did more than fill the holder");

  low_read_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    is_addr(io_rd_in, io_addr_in, timer16_pkg::ADDR_CNT_L) && !io_wr_in
    |=> temp_q == $past(counter_value_in[15:8])) // see [R6]
    else $error("low byte read did not capture the high byte");

  shared_temp_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    is_addr(io_rd_in, io_addr_in, timer16_pkg::ADDR_CAP_H)
    |=> io_rdata_out == $past(temp_q)) // see [R3]
    else $error("capture high byte not read from the holder");

  cmp_read_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    is_addr(io_rd_in, io_addr_in, timer16_pkg::ADDR_CMPA_H) && !io_wr_in
    |=> io_rdata_out == $past(buf_a_q[15:8]) && $stable(temp_q)) // see [R7]
    else $error("compare read disturbed the holder");

  bottom_reload_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    timer16_pkg::reload_at_bottom(wgm) && timer_tick_enable_in &&
    status_in.at_top && !status_in.at_bottom |=> $stable(cmp_a_q)) // see [R2]
    else $error("compare reloaded at top in frequency correct mode");

  tick_gate_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    timer16_pkg::wave_class(wgm) != timer16_pkg::WAVE_NONPWM &&
    !timer_tick_enable_in |=> $stable(cmp_b_q)) // see [R1]
    else $error("compare reloaded without a timer tick");

  pin_enable_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    conn_a && dir_a_in |=> waveform_out_a_out.enable &&
    waveform_out_a_out.override) // see [R11]
    else $error("connected output with direction out not driven");
endmodule : timer16_byte_access_compare_out

// >>> bench/counter_side_model.sv
// Stand-in for the counter, prescaler and compare logic around the block
`timescale 1ns/1ps
module counter_side_model (
  // Clock and reset
  input  wire logic                       sys_clk_in,
  input  wire logic                       rst_in,
  // Bench control
  input  wire logic                       run_in,
  input  wire logic                       dual_in,
  input  wire logic [15:0]                top_in,
  // From the block
  input  wire logic                       load_in,
  input  wire logic [15:0]                load_value_in,
  input  wire logic [15:0]                cmp_a_in,
  input  wire logic [15:0]                cmp_b_in,
  // To the block
  output logic                            tick_out,
  output logic [15:0]                     count_out,
  output timer16_pkg::counter_status_type status_out,
  output logic                            match_a_out,
  output logic                            match_b_out
);
  logic down_q;
  // Tick every second cycle so the block cannot treat it as a clock
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in)
      tick_out <= 1'b0;
    else
      tick_out <= run_in && !tick_out;
  end
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= 16'h0000;
      down_q <= 1'b0;
    end else if (load_in) begin
      count_out <= load_value_in;
    end else if (tick_out) begin
      if (!dual_in)
        count_out <= (count_out >= top_in) ? 16'h0000 : count_out + 16'h0001;
      else if (count_out >= top_in) begin
        down_q <= 1'b1;
        count_out <= count_out - 16'h0001;
      end else if (count_out == 16'h0000) begin
        down_q <= 1'b0;
        count_out <= 16'h0001;
      end else
        count_out <= down_q ? count_out - 16'h0001 : count_out + 16'h0001;
    end
  end
  assign status_out = '{at_top: count_out == top_in,
                        at_bottom: count_out == 16'h0000,
                        counting_down: down_q};
  // Matches only exist on a tick
  assign match_a_out = tick_out && (count_out == cmp_a_in);
  assign match_b_out = tick_out && (count_out == cmp_b_in);
endmodule : counter_side_model

// >>> bench/tb_top.sv
// Self-checking bench for the 16-bit timer access and compare output block
`timescale 1ns/1ps
module tb_top;
  logic                            sys_clk_in, rst_in, io_wr_in, io_rd_in;
  logic                            run, dual, dir_a_in, dir_b_in, tick;
  logic                            ma, mb, cnt_ld, cap_ld, rd_seen_q;
  logic [3:0]                      io_addr_in;
  logic [7:0]                      io_wdata_in, io_rdata_out, x;
  logic [1:0]                      wgm_hi, wgm_lo, m;
  logic [15:0]                     cnt, cap, top, ld_val, cmp_a, cmp_b, c;
  timer16_pkg::counter_status_type st;
  timer16_pkg::pin_drive_type      pa, pb;
  logic [7:0]                      exp_rd[$];
  logic [16:0]                     exp_ld[$];
  int                              error_cnt, n_compared, hi, e, f, i, k;

  timer16_byte_access_compare_out DUT (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .io_addr_in(io_addr_in),
    .io_wdata_in(io_wdata_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
    .io_rdata_out(io_rdata_out), .timer_tick_enable_in(tick),
    .counter_value_in(cnt), .capture_value_in(cap), .top_value_in(top),
    .status_in(st), .match_a_in(ma), .match_b_in(mb),
    .waveform_mode_hi_in(wgm_hi), .waveform_mode_lo_out(wgm_lo),
    .load_value_out(ld_val), .counter_load_out(cnt_ld),
    .capture_load_out(cap_ld), .compare_value_a_out(cmp_a),
    .compare_value_b_out(cmp_b), .dir_a_in(dir_a_in), .dir_b_in(dir_b_in),
    .waveform_out_a_out(pa), .waveform_out_b_out(pb));
  counter_side_model partner (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .run_in(run), .dual_in(dual),
    .top_in(top), .load_in(cnt_ld), .load_value_in(ld_val), .cmp_a_in(cmp_a),
    .cmp_b_in(cmp_b), .tick_out(tick), .count_out(cnt), .status_out(st),
    .match_a_out(ma), .match_b_out(mb));

  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask : check

  // Read data and load pulses are matched against the oldest note
  always @(posedge sys_clk_in) rd_seen_q <= io_rd_in;
  always @(negedge sys_clk_in) begin
    if (rd_seen_q === 1'b1) begin
      check(io_rdata_out, exp_rd.pop_front(), "read");
    end
    if (cnt_ld === 1'b1 || cap_ld === 1'b1) begin
      check({cap_ld, ld_val}, exp_ld.pop_front(), "load");
    end
  end

  task automatic give_verdict();
    if (exp_rd.size() + exp_ld.size() != 0) error_cnt++;
    $display("compared %0d, wrong %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // Strobes are reassigned every call, never twice in one time step
  task automatic acc(input bit w, input bit r, input logic [3:0] a,
                     input logic [7:0] d);
    io_wr_in = w;
    io_rd_in = r;
    io_addr_in = a;
    io_wdata_in = d;
    @(negedge sys_clk_in);
  endtask : acc
  task automatic idle();
    acc(1'b0, 1'b0, 4'h0, 8'h00);
  endtask : idle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    acc(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] ex);
    exp_rd.push_back(ex);
    acc(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  task automatic w16(input logic [3:0] a, input logic [15:0] v);
    wr(a + 4'h1, v[15:8]);
    wr(a, v[7:0]);
    idle();
  endtask : w16
  task automatic wait_ev(input int sel);
    int n;
    n = 0;
    while (!(tick === 1'b1 && ((sel == 0) ? st.at_top :
             (sel == 1) ? st.at_bottom : ma) === 1'b1)) begin
      n++;
      if (n > 500) begin
        error_cnt++;
        $display("wrong value at %0t: event never came", $time);
        give_verdict();
      end
      @(negedge sys_clk_in);
    end
  endtask : wait_ev
  task automatic settle();
    repeat (3) @(negedge sys_clk_in);
  endtask : settle

  initial begin
    rst_in = 1'b1;
    io_wr_in = 1'b0;
    io_rd_in = 1'b0;
    io_addr_in = 4'h0;
    io_wdata_in = 8'h00;
    {run, dual, wgm_hi} = 4'h0;
    {dir_a_in, dir_b_in} = 2'b11;
    top = 16'h0009;
    error_cnt = 0;
    n_compared = 0;
    void'($urandom(32'hbd09b03a));
    cap = 16'($urandom);
    x = 8'($urandom);
    repeat (6) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_in = 1'b0;
    check({pa, pb, cmp_a}, 22'h0, "reset outputs");
    rd(timer16_pkg::ADDR_CTRL_A, timer16_pkg::CTRL_A_RESET);
    wr(timer16_pkg::ADDR_CTRL_A, x);
    rd(timer16_pkg::ADDR_CTRL_A, x);
    for (i = 9; i < 16; i++) begin
      wr(4'(i), x);
      rd(4'(i), 8'h00);
    end
    wr(timer16_pkg::ADDR_CTRL_A, 8'h00);
    idle();
    $display("test registers done");
    // Counter written, then advanced between the two byte reads
    exp_ld.push_back({1'b0, 16'h01ff});
    w16(timer16_pkg::ADDR_CNT_L, 16'h01ff);
    rd(timer16_pkg::ADDR_CNT_L, 8'hff);
    run = 1'b1;
    idle();
    idle();
    run = 1'b0;
    rd(timer16_pkg::ADDR_CNT_H, 8'h01);
    rd(timer16_pkg::ADDR_CNT_L, 8'h00);
    rd(timer16_pkg::ADDR_CNT_H, 8'h00);
    rd(timer16_pkg::ADDR_CAP_L, cap[7:0]);
    rd(timer16_pkg::ADDR_CAP_H, cap[15:8]);
    exp_ld.push_back({1'b1, cap ^ 16'h5a5a});
    w16(timer16_pkg::ADDR_CAP_L, cap ^ 16'h5a5a);
    // One holder write serves both compare low writes
    wr(timer16_pkg::ADDR_CMPA_H, 8'h00);
    wr(timer16_pkg::ADDR_CMPA_L, 8'h05);
    wr(timer16_pkg::ADDR_CMPB_L, 8'h07);
    idle();
    idle();
    check({cmp_a, cmp_b}, 32'h0005_0007, "holder");
    wr(timer16_pkg::ADDR_CNT_H, 8'ha5);
    rd(timer16_pkg::ADDR_CMPA_H, 8'h00);
    rd(timer16_pkg::ADDR_CMPA_L, 8'h05);
    exp_ld.push_back({1'b0, 16'ha53c});
    wr(timer16_pkg::ADDR_CNT_L, 8'h3c);
    idle();
    $display("test holder done");
    run = 1'b1;
    for (i = 0; i < 4; i++) begin
      m = (i == 0) ? 2'h3 : (i == 1) ? 2'h2 : 2'h1;
      wr(timer16_pkg::ADDR_CTRL_A, {m, 6'h00});
      idle();
      wait_ev(2);
      settle();
      check(pa, {(i == 0 || i == 2), 2'b11}, "non-pwm pin");
    end
    dir_a_in = 1'b0;
    settle();
    check(pa, 3'b001, "direction in");
    dir_a_in = 1'b1;
    wr(timer16_pkg::ADDR_CTRL_A, 8'h00);
    idle();
    settle();
    check(pa[1:0], 2'b00, "disconnected");
    wr(timer16_pkg::ADDR_CTRL_A, 8'h51);
    idle();
    settle();
    check({pa.override, pb.override}, 2'b00, "code 01 bit3 low");
    wgm_hi = 2'b11;
    wr(timer16_pkg::ADDR_CTRL_A, 8'h52);
    idle();
    settle();
    check({pa.override, pb.override}, 2'b10, "code 01 bit3 high");
    $display("test pins done");
    // Duty over one period: fast mode 14, then dual mode 8
    for (k = 0; k < 12; k++) begin
      f = k / 6;
      c = (k % 3 == 0) ? 16'h0000 : (k % 3 == 1) ? 16'h0004 : top;
      m = 2'(2 + (k / 3) % 2);
      dual = f[0];
      wgm_hi = f[0] ? 2'b10 : 2'b11;
      w16(timer16_pkg::ADDR_CMPA_L, c);
      wr(timer16_pkg::ADDR_CTRL_A, {m, 4'h0, f[0] ? 2'b00 : 2'b10});
      idle();
      repeat (80) @(negedge sys_clk_in);
      hi = 0;
      repeat (f ? 36 : 20) begin
        @(negedge sys_clk_in);
        hi += int'(pa.level === 1'b1);
      end
      if (f != 0) e = (c == 0) ? 0 : (c == top) ? 36 : 4 * c;
      else e = (c == top) ? 20 : 2 * c;
      if (m == 2'h3) e = (f ? 36 : 20) - e;
      check(hi, e, "pwm duty");
    end
    check(wgm_lo, 2'b00, "mode low bits");
    $display("test pwm done");
    // Compare reload waits for BOTTOM, not TOP
    wait_ev(1);
    w16(timer16_pkg::ADDR_CMPA_L, 16'h0002);
    wait_ev(0);
    settle();
    check(cmp_a, top, "no reload at top");
    wait_ev(1);
    settle();
    check(cmp_a, 16'h0002, "reload at bottom");
    run = 1'b0;
    $display("test reload done");
    give_verdict();
  end
endmodule : tb_top
